/* shared/dosc_pkg.sv */
`default_nettype none
package dosc_pkg;
  // Register offsets
  localparam logic [7:0] DOSC_ADDR_SRCSEL = 8'h85;
  localparam logic [7:0] DOSC_ADDR_OSCCTL = 8'h86;
  localparam logic [7:0] DOSC_ADDR_CLKMODE = 8'h8f;
  // Field positions
  localparam int DOSC_BIT_SRC = 0;
  localparam int DOSC_BIT_PEN = 0;
  localparam int DOSC_BIT_SEN = 1;
  localparam int DOSC_BIT_T0SUB = 2;
  localparam int DOSC_BIT_UNDIV = 0;
  // Reset values before the fuse load
  localparam logic DOSC_RST_BIT = 1'b0;
  localparam logic [7:0] DOSC_RD_ZERO = 8'h00;
  // Timer 0 sub-clock divider, 128 = 2**7
  localparam int DOSC_T0DIV_W = 7;
  localparam logic [DOSC_T0DIV_W-1:0] DOSC_T0DIV_ONE = 7'h01;

  typedef struct packed {
    logic timer0_subclock_select;
    logic secondary_osc_enable;
    logic primary_osc_enable;
  } dosc_ctrl_t;

  typedef struct packed {
    logic primary_run;
    logic secondary_run;
    logic secondary_pins_free;
  } dosc_osc_t;
endpackage
`default_nettype wire

/* core/dosc_switch.sv */
`default_nettype none
module dosc_switch
  import dosc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic osc_select_fuse,
  input wire logic undivided_fuse,
  input wire logic idle_mode,
  input wire logic power_down_mode,
  input wire logic primary_oscillator,
  input wire logic secondary_oscillator,
  input wire logic timer0_count_pin,
  output logic system_clock,
  output logic timer0_count_in,
  output dosc_osc_t osc_status
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic init_done_q;
  logic src_sel_q;
  logic undiv_q;
  dosc_ctrl_t ctrl_q;
  dosc_ctrl_t wr_ctrl;
  logic low_power;
  logic wr_src;
  logic wr_ctl;
  logic wr_mode;

  assign low_power = idle_mode | power_down_mode;
  assign wr_src = init_done_q & reg_wr & (reg_addr == DOSC_ADDR_SRCSEL);
  assign wr_ctl = init_done_q & reg_wr & (reg_addr == DOSC_ADDR_OSCCTL);
  assign wr_mode = init_done_q & reg_wr & (reg_addr == DOSC_ADDR_CLKMODE);

  // fuse caught on the first edge after release, never in the reset term
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      init_done_q <= DOSC_RST_BIT;
    end else begin
      init_done_q <= 1'b1;
    end
  end

  always_comb begin
    wr_ctrl.timer0_subclock_select = reg_wdata[DOSC_BIT_T0SUB];
    wr_ctrl.primary_osc_enable = reg_wdata[DOSC_BIT_PEN];
    wr_ctrl.secondary_osc_enable = reg_wdata[DOSC_BIT_SEN];
    // active oscillator enable cannot be cleared
    if (src_sel_q) begin
      wr_ctrl.primary_osc_enable = 1'b1;
    end else begin
      wr_ctrl.secondary_osc_enable = 1'b1;
    end
  end

  // enables and select follow the fuse after any reset
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= '0;
    end else if (!init_done_q) begin
      ctrl_q.primary_osc_enable <= osc_select_fuse;
      ctrl_q.secondary_osc_enable <= ~osc_select_fuse;
      ctrl_q.timer0_subclock_select <= 1'b0;
    end else if (wr_ctl) begin
      // only software writes move these, wake-up leaves them alone
      ctrl_q <= wr_ctrl;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      src_sel_q <= DOSC_RST_BIT;
    end else if (!init_done_q) begin
      src_sel_q <= osc_select_fuse;
    end else if (wr_src && !low_power) begin
      // a switch toward a disabled oscillator is dropped
      if (reg_wdata[DOSC_BIT_SRC] ? ctrl_q.primary_osc_enable
                                  : ctrl_q.secondary_osc_enable) begin
        src_sel_q <= reg_wdata[DOSC_BIT_SRC];
      end
    end
  end

  // inverse of fuse at reset, software may rewrite freely
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      undiv_q <= DOSC_RST_BIT;
    end else if (!init_done_q) begin
      undiv_q <= ~undivided_fuse;
    end else if (wr_mode) begin
      undiv_q <= reg_wdata[DOSC_BIT_UNDIV];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= DOSC_RD_ZERO;
    end else if (reg_rd) begin
      unique case (reg_addr)
        DOSC_ADDR_SRCSEL: reg_rdata <= {7'h00, src_sel_q};
        DOSC_ADDR_OSCCTL: reg_rdata <= {5'h00, ctrl_q};
        DOSC_ADDR_CLKMODE: reg_rdata <= {7'h00, undiv_q};
        default: reg_rdata <= DOSC_RD_ZERO;
      endcase
    end else begin
      // Zero outside the answer cycle, so read data from several blocks can be OR-ed
      reg_rdata <= DOSC_RD_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator power

  logic prim_run;
  logic sec_run;

  // power-down stops both; idle keeps enabled ones going
  assign prim_run = ctrl_q.primary_osc_enable & ~power_down_mode;
  assign sec_run = ctrl_q.secondary_osc_enable & ~power_down_mode;

  // a cleared enable powers the source down; a cleared secondary enable also frees the crystal pins
  assign osc_status.primary_run = prim_run;
  assign osc_status.secondary_run = sec_run;
  assign osc_status.secondary_pins_free = ~ctrl_q.secondary_osc_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Glitch-free source handover

  logic prim_q;
  logic sec_q;
  logic prim_fall;
  logic sec_fall;
  logic sec_rise;
  logic pa1_q;
  logic pa2_q;
  logic sb1_q;
  logic sb2_q;
  logic osc_mux;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prim_q <= 1'b0;
      sec_q <= 1'b0;
    end else begin
      prim_q <= primary_oscillator & prim_run;
      sec_q <= secondary_oscillator & sec_run;
    end
  end

  assign prim_fall = prim_q & ~(primary_oscillator & prim_run);
  assign sec_fall = sec_q & ~(secondary_oscillator & sec_run);
  assign sec_rise = ~sec_q & secondary_oscillator & sec_run;

  // each gate opens on its own falling edge, only after the other closed
  // two falling edges per source bound the handover
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pa1_q <= 1'b0;
      pa2_q <= 1'b0;
    end else if (!prim_run) begin
      // A dead source cannot clock its gate shut, so close it directly
      pa1_q <= 1'b0;
      pa2_q <= 1'b0;
    end else if (prim_fall) begin
      pa1_q <= src_sel_q & ~sb2_q;
      pa2_q <= pa1_q & src_sel_q & ~sb2_q;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sb1_q <= 1'b0;
      sb2_q <= 1'b0;
    end else if (!sec_run) begin
      sb1_q <= 1'b0;
      sb2_q <= 1'b0;
    end else if (sec_fall) begin
      sb1_q <= ~src_sel_q & ~pa2_q;
      sb2_q <= sb1_q & ~src_sel_q & ~pa2_q;
    end
  end

  // only one gate can be open, so one source reaches the clock
  assign osc_mux = (prim_q & pa2_q) | (sec_q & sb2_q);

  ////////////////////////////////////////////////////////////////////////////
  // Halved clock mode

  logic mux_q;
  logic sys_clk_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mux_q <= 1'b0;
    end else begin
      mux_q <= osc_mux;
    end
  end

  // toggle on each rising edge for 50% duty, else pass through
  // divider sits after the mux, so both sources see it alike
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sys_clk_q <= 1'b0;
    end else if (undiv_q) begin
      sys_clk_q <= osc_mux;
    end else if (osc_mux && !mux_q) begin
      sys_clk_q <= ~sys_clk_q;
    end
  end

  assign system_clock = sys_clk_q;

  ////////////////////////////////////////////////////////////////////////////
  // Timer 0 count source

  logic [DOSC_T0DIV_W-1:0] t0div_q;
  logic t0_q;

  // Counts only while the secondary runs, so it freezes in power-down
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      t0div_q <= '0;
    end else if (sec_rise) begin
      t0div_q <= t0div_q + DOSC_T0DIV_ONE;
    end
  end

  // msb of the 7-bit counter is the secondary divided by 128
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      t0_q <= 1'b0;
    end else if (ctrl_q.timer0_subclock_select) begin
      t0_q <= t0div_q[DOSC_T0DIV_W-1];
    end else begin
      t0_q <= timer0_count_pin;
    end
  end

  assign timer0_count_in = t0_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  src_exclusive_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !(pa2_q && sb2_q)) else $error("both source gates open");

  active_enabled_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    init_done_q |-> (src_sel_q ? ctrl_q.primary_osc_enable
                               : ctrl_q.secondary_osc_enable))
    else $error("active oscillator disabled");

  refuse_switch_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_src && !low_power && (reg_wdata[DOSC_BIT_SRC] != src_sel_q) &&
    !(reg_wdata[DOSC_BIT_SRC] ? ctrl_q.primary_osc_enable
                              : ctrl_q.secondary_osc_enable) |=> $stable(src_sel_q))
    else $error("switch to disabled oscillator taken");

  lowpower_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    low_power && wr_src |=> $stable(src_sel_q)) else $error("select moved in low power");

  fuse_load_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !init_done_q ##1 init_done_q |-> src_sel_q == $past(osc_select_fuse) &&
    ctrl_q.primary_osc_enable == $past(osc_select_fuse) &&
    ctrl_q.secondary_osc_enable != $past(osc_select_fuse) &&
    !ctrl_q.timer0_subclock_select && undiv_q != $past(undivided_fuse))
    else $error("fuse defaults wrong");

  retain_ctrl_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    init_done_q && !wr_ctl && !wr_src |=> $stable(ctrl_q) && $stable(src_sel_q))
    else $error("control bits changed without a write");

  // Run flags drop at once, the gates are shut one edge later
  pd_stop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    power_down_mode |-> (!osc_status.primary_run && !osc_status.secondary_run) ##1
    (!pa2_q && !sb2_q)) else $error("oscillator alive in power-down");

  t0_route_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    ##1 timer0_count_in == ($past(ctrl_q.timer0_subclock_select) ?
    $past(t0div_q[DOSC_T0DIV_W-1]) : $past(timer0_count_pin)))
    else $error("timer 0 count source wrong");

  halve_toggle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !undiv_q && osc_mux && !mux_q |=> system_clock != $past(system_clock))
    else $error("halved clock missed a toggle");

  pass_through_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    undiv_q |=> system_clock == $past(osc_mux)) else $error("undivided clock not passed");

  select_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_src && !low_power && (reg_wdata[DOSC_BIT_SRC] ? ctrl_q.primary_osc_enable
                                                     : ctrl_q.secondary_osc_enable) |=>
    src_sel_q == $past(reg_wdata[DOSC_BIT_SRC])) else $error("legal switch not taken");

  // A stopped source must leave its sampler and gate idle, and a stopped secondary its divider too
  prim_dead_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !prim_run |=> !prim_q && !pa1_q && !pa2_q) else $error("stopped primary still gated");

  sec_dead_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    !sec_run |=> !sec_q && !sb1_q && !sb2_q && $stable(t0div_q))
    else $error("stopped secondary still active");

  ctrl_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_ctl |=> ctrl_q.timer0_subclock_select == $past(reg_wdata[DOSC_BIT_T0SUB]))
    else $error("timer 0 source select not written");

  undiv_write_a: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_mode |=> undiv_q == $past(reg_wdata[DOSC_BIT_UNDIV]))
    else $error("undivided select not written");

  switch_to_prim_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    !src_sel_q ##1 src_sel_q ##[1:200] pa2_q);
  switch_to_sec_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    src_sel_q ##1 !src_sel_q ##[1:200] sb2_q);
  refused_clear_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    wr_ctl && src_sel_q && !reg_wdata[DOSC_BIT_PEN]);
  pd_wake_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    power_down_mode ##1 !power_down_mode);
  idle_block_c: cover property (@(posedge sys_clk) disable iff (!resetn)
    idle_mode && wr_src && (reg_wdata[DOSC_BIT_SRC] != src_sel_q));

endmodule
`default_nettype wire

/* verification/test_dosc_switch.sv */
`default_nettype none
module test_dosc_switch
  import dosc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic osc_select_fuse = 1'b1;
  logic undivided_fuse = 1'b0;
  logic idle_mode = 1'b0;
  logic power_down_mode = 1'b0;
  logic primary_oscillator = 1'b0;
  logic secondary_oscillator = 1'b0;
  logic timer0_count_pin = 1'b0;
  logic system_clock;
  logic timer0_count_in;
  dosc_osc_t osc_status;
  int num_errors = 0;
  int n_compared = 0;
  int pcnt = 0;
  int scnt = 0;

  always #2 sys_clk = ~sys_clk;

  // Primary period 6 cycles, secondary period 10 cycles
  always @(posedge sys_clk) begin
    pcnt <= (pcnt == 2) ? 0 : pcnt + 1;
    scnt <= (scnt == 4) ? 0 : scnt + 1;
    if (pcnt == 2) primary_oscillator <= ~primary_oscillator;
    if (scnt == 4) secondary_oscillator <= ~secondary_oscillator;
  end

  dosc_switch dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .osc_select_fuse(osc_select_fuse), .undivided_fuse(undivided_fuse),
    .idle_mode(idle_mode), .power_down_mode(power_down_mode),
    .primary_oscillator(primary_oscillator), .secondary_oscillator(secondary_oscillator),
    .timer0_count_pin(timer0_count_pin), .system_clock(system_clock),
    .timer0_count_in(timer0_count_in), .osc_status(osc_status));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic do_reset(input logic fuse, input logic ufuse);
    resetn <= 1'b0;
    osc_select_fuse <= fuse;
    undivided_fuse <= ufuse;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands in the cycle after the strobe and is taken at its closing edge
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk($sformatf("reg %h", a), reg_rdata, exp);
  endtask

  // Rising edges of system_clock, or of timer0_count_in when t0 is set
  // Exact count for the timer and for a stopped clock, one edge of slack otherwise
  task automatic rises(input int n, input bit t0, input int exp);
    logic p;
    int c;
    int tol;
    c = 0;
    tol = (t0 || exp == 0) ? 0 : 1;
    p = t0 ? timer0_count_in : system_clock;
    repeat (n) begin
      @(posedge sys_clk);
      if ((t0 ? timer0_count_in : system_clock) === 1'b1 && p === 1'b0) c++;
      p = t0 ? timer0_count_in : system_clock;
    end
    chk("edge count in range", 8'((c >= exp - tol) && (c <= exp + tol)), 8'h01);
  endtask

  task automatic stchk(input logic [2:0] exp);
    @(posedge sys_clk);
    chk("osc_status", {5'h00, osc_status}, {5'h00, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    do_reset(1'b1, 1'b0);
    rdchk(DOSC_ADDR_SRCSEL, 8'h01);
    rdchk(DOSC_ADDR_OSCCTL, 8'h01);
    rdchk(DOSC_ADDR_CLKMODE, 8'h01);
    rdchk(8'h90, 8'h00);
    stchk(3'b101);
    do_reset(1'b0, 1'b1);
    rdchk(DOSC_ADDR_SRCSEL, 8'h00);
    rdchk(DOSC_ADDR_OSCCTL, 8'h02);
    rdchk(DOSC_ADDR_CLKMODE, 8'h00);
    stchk(3'b010);
    $display("test defaults done");
  endtask

  task automatic t_interlock;
    do_reset(1'b1, 1'b0);
    wr(DOSC_ADDR_OSCCTL, 8'h00);
    rdchk(DOSC_ADDR_OSCCTL, 8'h01);
    wr(DOSC_ADDR_SRCSEL, 8'h00);
    rdchk(DOSC_ADDR_SRCSEL, 8'h01);
    wr(DOSC_ADDR_OSCCTL, 8'h03);
    idle_mode <= 1'b1;
    wr(DOSC_ADDR_SRCSEL, 8'h00);
    rdchk(DOSC_ADDR_SRCSEL, 8'h01);
    stchk(3'b110);
    idle_mode <= 1'b0;
    rdchk(DOSC_ADDR_OSCCTL, 8'h03);
    $display("test interlock done");
  endtask

  // software order: enable, wait, switch, disable old source
  task automatic t_switch;
    // settle wait: secondary was enabled in the previous test
    rises(60, 1'b0, 10);
    wr(DOSC_ADDR_SRCSEL, 8'h00);
    rdchk(DOSC_ADDR_SRCSEL, 8'h00);
    repeat (40) @(posedge sys_clk);
    rises(60, 1'b0, 6);
    wr(DOSC_ADDR_OSCCTL, 8'h02);
    rdchk(DOSC_ADDR_OSCCTL, 8'h02);
    stchk(3'b010);
    wr(DOSC_ADDR_OSCCTL, 8'h00);
    rdchk(DOSC_ADDR_OSCCTL, 8'h02);
    wr(DOSC_ADDR_CLKMODE, 8'h00);
    rdchk(DOSC_ADDR_CLKMODE, 8'h00);
    rises(120, 1'b0, 6);
    $display("test switch done");
  endtask

  task automatic t_pdown;
    wr(DOSC_ADDR_OSCCTL, 8'h03);
    power_down_mode <= 1'b1;
    stchk(3'b000);
    wr(DOSC_ADDR_SRCSEL, 8'h01);
    rdchk(DOSC_ADDR_SRCSEL, 8'h00);
    repeat (4) @(posedge sys_clk);
    rises(40, 1'b0, 0);
    power_down_mode <= 1'b0;
    rdchk(DOSC_ADDR_SRCSEL, 8'h00);
    rdchk(DOSC_ADDR_OSCCTL, 8'h03);
    do_reset(1'b1, 1'b0);
    rdchk(DOSC_ADDR_OSCCTL, 8'h01);
    $display("test power down done");
  endtask

  task automatic t_timer;
    do_reset(1'b0, 1'b1);
    timer0_count_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk("timer0_count_in", {7'h00, timer0_count_in}, 8'h01);
    timer0_count_pin <= 1'b0;
    wr(DOSC_ADDR_OSCCTL, 8'h06);
    rdchk(DOSC_ADDR_OSCCTL, 8'h06);
    rises(2600, 1'b1, 2);
    $display("test timer done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    t_defaults();
    t_interlock();
    t_switch();
    t_pdown();
    t_timer();
    end_sim();
  end

  initial begin
    #80000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
